/* design/brake_output_defs.vh */
// Register map, field layout, reset values and codes of the brake output set-up block.
`ifndef BRAKE_OUTPUT_DEFS_VH
`define BRAKE_OUTPUT_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BRK_OFS_CTRL 8'h00
`define BRK_OFS_STATUS 8'h04
`define BRK_OFS_ROUTING 8'h08
`define BRK_OFS_MOTION 8'h0C
`define BRK_OFS_DRIVE 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BRK_ROUTE_IO2_INV 0
`define BRK_ROUTE_IO2_SRC_LO 1
`define BRK_ROUTE_IO2_DIR 3
`define BRK_ROUTE_RLY_INV 4
`define BRK_ROUTE_RLY_SRC_LO 5
`define BRK_MOT_RAMP_HOLD 0
`define BRK_MOT_ZERO_SPEED_HOLD 1
`define BRK_MOT_POS_REF_SEL 2
`define BRK_MOT_POS_MODE 3
`define BRK_MOT_POS_BY_BRAKE 4
`define BRK_DRIVE_RESET_BIT 8

// ----------------------------------------------------------------
// Controller settings, drive modes and routing sources
// ----------------------------------------------------------------
`define BRK_SEL_OFF 2'h0
`define BRK_SEL_RELAY 2'h1
`define BRK_SEL_IO2 2'h2
`define BRK_SEL_USER 2'h3
`define BRK_MODE_OPEN_LOOP 2'h0
`define BRK_SRC_NONE 2'h0
`define BRK_SRC_RESET_REQ 2'h1
`define BRK_SRC_DRIVE_OK 2'h2
`define BRK_SRC_BRAKE 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BRK_RST_SEL 2'h0
`define BRK_RST_MODE 2'h0

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define BRK_RESP_OKAY 2'h0
`define BRK_RESP_SLVERR 2'h2

`endif

/* design/brake_reconfig_seq.v */
// Two-stage sequencer that orders the restore and set-up passes at drive reset.
`timescale 1ns/1ps
`default_nettype none

`include "brake_output_defs.vh"

module brake_reconfig_seq (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire [1:0] pending_sel,
  input wire [1:0] active_sel,
  output reg restore_ff,
  output reg setup_ff,
  output reg [1:0] old_sel_ff,
  output reg [1:0] new_sel_ff,
  output reg busy_ff
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RESTORE = 2'h1;
  localparam [1:0] ST_SETUP = 2'h2;

  reg [1:0] state_ff;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      restore_ff <= 1'b0;
      setup_ff <= 1'b0;
      old_sel_ff <= `BRK_RST_SEL;
      new_sel_ff <= `BRK_RST_SEL;
      busy_ff <= 1'b0;
    end else begin
      restore_ff <= 1'b0;
      setup_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // A changed setting is only taken when a drive reset arrives.
          if (start && (pending_sel != active_sel)) begin
            old_sel_ff <= active_sel;
            new_sel_ff <= pending_sel;
            busy_ff <= 1'b1;
            state_ff <= ST_RESTORE;
          end
        end
        ST_RESTORE: begin
          // The old routing is undone strictly before the new one is applied.
          restore_ff <= 1'b1;
          state_ff <= ST_SETUP;
        end
        ST_SETUP: begin
          setup_ff <= 1'b1;
          busy_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule // brake_reconfig_seq

`default_nettype wire

/* design/brake_output_setup.v */
// Brake output selection and automatic terminal routing with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

`include "brake_output_defs.vh"

module brake_output_setup #(
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire brake_release_req,
  input wire drive_ok,
  input wire io2_in,
  output reg io2_out_ff,
  output reg io2_oe_ff,
  output reg relay_out_ff,
  output reg brake_release_flag_ff,
  output reg controller_enabled_ff,
  output reg drive_reset_ff,
  output reg ramp_hold_ff,
  output reg zero_speed_hold_ff,
  output reg posctl_ref_select_ff,
  output reg posctl_mode_ff
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [1:0] pending_sel_ff;
  reg [1:0] active_sel_ff;
  reg [1:0] drive_mode_ff;
  reg posctl_enable_by_brake_ff;
  reg io2_invert_ff;
  reg [1:0] io2_route_ff;
  reg io2_direction_ff;
  reg relay_invert_ff;
  reg [1:0] relay_source_ff;
  reg aw_full_ff;
  reg w_full_ff;
  reg [ADDR_W-1:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg sw_reset_ff;
  reg io2_req_prev_ff;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;
  reg io2_drive;
  reg relay_drive;
  wire restore_stb;
  wire setup_stb;
  wire [1:0] old_sel;
  wire [1:0] new_sel;
  wire seq_busy;
  wire wr_go;
  wire wr_lane0;
  wire io2_req;
  wire reset_start;

  // ----------------------------------------------------------------
  // Drive reset and stage sequencer
  // ----------------------------------------------------------------
  assign io2_req = ~io2_direction_ff & (io2_route_ff == `BRK_SRC_RESET_REQ) & io2_in;
  assign reset_start = sw_reset_ff | (io2_req & ~io2_req_prev_ff);

  brake_reconfig_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(reset_start),
    .pending_sel(pending_sel_ff),
    .active_sel(active_sel_ff),
    .restore_ff(restore_stb),
    .setup_ff(setup_stb),
    .old_sel_ff(old_sel),
    .new_sel_ff(new_sel),
    .busy_ff(seq_busy)
  );

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_full_ff & w_full_ff & ~bvalid;
  assign wr_lane0 = wr_go & w_strb_ff[0];

  always @* begin
    wr_hit = 1'b1;
    case (aw_addr_ff)
      `BRK_OFS_CTRL: wr_hit = 1'b1;
      `BRK_OFS_STATUS: wr_hit = 1'b1;
      `BRK_OFS_ROUTING: wr_hit = 1'b1;
      `BRK_OFS_MOTION: wr_hit = 1'b1;
      `BRK_OFS_DRIVE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= {ADDR_W{1'b0}};
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `BRK_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= awaddr;
        awready <= 1'b0;
      end else if (!aw_full_ff && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
        wready <= 1'b0;
      end else if (!w_full_ff && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_go) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `BRK_RESP_OKAY : `BRK_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (araddr)
      `BRK_OFS_CTRL: rd_word[1:0] = pending_sel_ff;
      `BRK_OFS_STATUS: rd_word[6:0] = {drive_ok, io2_in, seq_busy, controller_enabled_ff,
                                        active_sel_ff, brake_release_flag_ff};
      `BRK_OFS_ROUTING: rd_word[6:0] = {relay_source_ff, relay_invert_ff, io2_direction_ff,
                                         io2_route_ff, io2_invert_ff};
      `BRK_OFS_MOTION: rd_word[4:0] = {posctl_enable_by_brake_ff, posctl_mode_ff,
                                        posctl_ref_select_ff, zero_speed_hold_ff,
                                        ramp_hold_ff};
      `BRK_OFS_DRIVE: rd_word[1:0] = drive_mode_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `BRK_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_hit ? `BRK_RESP_OKAY : `BRK_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings and drive reset request
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pending_sel_ff <= `BRK_RST_SEL;
      drive_mode_ff <= `BRK_RST_MODE;
      sw_reset_ff <= 1'b0;
      io2_req_prev_ff <= 1'b0;
    end else begin
      io2_req_prev_ff <= io2_req;
      sw_reset_ff <= 1'b0;
      if (wr_lane0 && aw_addr_ff == `BRK_OFS_CTRL) begin
        pending_sel_ff <= w_data_ff[1:0];
      end
      if (wr_lane0 && aw_addr_ff == `BRK_OFS_DRIVE) begin
        drive_mode_ff <= w_data_ff[1:0];
      end
      if (wr_go && w_strb_ff[1] && aw_addr_ff == `BRK_OFS_DRIVE) begin
        sw_reset_ff <= w_data_ff[`BRK_DRIVE_RESET_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Applied setting and motion settings
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      active_sel_ff <= `BRK_RST_SEL;
      ramp_hold_ff <= 1'b0;
      zero_speed_hold_ff <= 1'b0;
      posctl_ref_select_ff <= 1'b0;
      posctl_mode_ff <= 1'b0;
      posctl_enable_by_brake_ff <= 1'b0;
    end else begin
      if (wr_lane0 && aw_addr_ff == `BRK_OFS_MOTION) begin
        ramp_hold_ff <= w_data_ff[`BRK_MOT_RAMP_HOLD];
        zero_speed_hold_ff <= w_data_ff[`BRK_MOT_ZERO_SPEED_HOLD];
        posctl_ref_select_ff <= w_data_ff[`BRK_MOT_POS_REF_SEL];
        posctl_mode_ff <= w_data_ff[`BRK_MOT_POS_MODE];
        posctl_enable_by_brake_ff <= w_data_ff[`BRK_MOT_POS_BY_BRAKE];
      end
      if (setup_stb) begin
        active_sel_ff <= new_sel;
        if (old_sel != `BRK_SEL_OFF && new_sel == `BRK_SEL_OFF) begin
          ramp_hold_ff <= 1'b0;
          if (drive_mode_ff != `BRK_MODE_OPEN_LOOP) begin
            zero_speed_hold_ff <= 1'b0;
            if (posctl_enable_by_brake_ff) begin
              posctl_ref_select_ff <= 1'b0;
              posctl_mode_ff <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Terminal routing
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      io2_invert_ff <= 1'b0;
      io2_route_ff <= `BRK_SRC_RESET_REQ;
      io2_direction_ff <= 1'b0;
      relay_invert_ff <= 1'b0;
      relay_source_ff <= `BRK_SRC_DRIVE_OK;
    end else if (restore_stb) begin
      case (old_sel)
        `BRK_SEL_RELAY: begin
          io2_invert_ff <= 1'b0;
          io2_route_ff <= `BRK_SRC_RESET_REQ;
          io2_direction_ff <= 1'b0;
          relay_invert_ff <= 1'b0;
          relay_source_ff <= `BRK_SRC_DRIVE_OK;
        end
        `BRK_SEL_IO2: begin
          io2_invert_ff <= 1'b0;
          io2_route_ff <= `BRK_SRC_RESET_REQ;
          io2_direction_ff <= 1'b0;
        end
        default: begin
          io2_invert_ff <= io2_invert_ff;
        end
      endcase
    end else if (setup_stb) begin
      case (new_sel)
        `BRK_SEL_RELAY: begin
          io2_invert_ff <= 1'b0;
          io2_route_ff <= `BRK_SRC_DRIVE_OK;
          io2_direction_ff <= 1'b1;
          relay_invert_ff <= 1'b0;
          relay_source_ff <= `BRK_SRC_BRAKE;
        end
        `BRK_SEL_IO2: begin
          io2_invert_ff <= 1'b0;
          io2_route_ff <= `BRK_SRC_BRAKE;
          io2_direction_ff <= 1'b1;
        end
        default: begin
          io2_invert_ff <= io2_invert_ff;
        end
      endcase
    end else if (wr_lane0 && aw_addr_ff == `BRK_OFS_ROUTING) begin
      io2_invert_ff <= w_data_ff[`BRK_ROUTE_IO2_INV];
      io2_route_ff <= w_data_ff[`BRK_ROUTE_IO2_SRC_LO+1:`BRK_ROUTE_IO2_SRC_LO];
      io2_direction_ff <= w_data_ff[`BRK_ROUTE_IO2_DIR];
      relay_invert_ff <= w_data_ff[`BRK_ROUTE_RLY_INV];
      relay_source_ff <= w_data_ff[`BRK_ROUTE_RLY_SRC_LO+1:`BRK_ROUTE_RLY_SRC_LO];
    end
  end

  // ----------------------------------------------------------------
  // Output terminals and release flag
  // ----------------------------------------------------------------
  always @* begin
    case (io2_route_ff)
      `BRK_SRC_BRAKE: io2_drive = brake_release_flag_ff;
      `BRK_SRC_DRIVE_OK: io2_drive = drive_ok;
      default: io2_drive = 1'b0;
    endcase
    case (relay_source_ff)
      `BRK_SRC_BRAKE: relay_drive = brake_release_flag_ff;
      `BRK_SRC_DRIVE_OK: relay_drive = drive_ok;
      default: relay_drive = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      brake_release_flag_ff <= 1'b0;
      controller_enabled_ff <= 1'b0;
      drive_reset_ff <= 1'b0;
      io2_out_ff <= 1'b0;
      io2_oe_ff <= 1'b0;
      relay_out_ff <= 1'b0;
    end else begin
      controller_enabled_ff <= (active_sel_ff != `BRK_SEL_OFF);
      brake_release_flag_ff <= (active_sel_ff != `BRK_SEL_OFF) & brake_release_req;
      drive_reset_ff <= reset_start;
      io2_out_ff <= io2_direction_ff & (io2_drive ^ io2_invert_ff);
      io2_oe_ff <= io2_direction_ff;
      relay_out_ff <= relay_drive ^ relay_invert_ff;
    end
  end

endmodule // brake_output_setup

`default_nettype wire

/* tb/brake_output_setup_chk.sv */
// Concurrent checks on the ports of the brake output set-up block.
`timescale 1ns/1ps
`default_nettype none
module brake_output_setup_chk #(
  parameter ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic brake_release_req,
  input wire logic io2_out_ff,
  input wire logic io2_oe_ff,
  input wire logic brake_release_flag_ff,
  input wire logic controller_enabled_ff,
  input wire logic drive_reset_ff,
  input wire logic ramp_hold_ff
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_flag_needs_enable: assert property (brake_release_flag_ff |-> controller_enabled_ff)
    else $error("release flag high with controller off");
  a_flag_releases: assert property ((controller_enabled_ff && brake_release_req) [*3]
    |-> brake_release_flag_ff) else $error("release flag low on request");
  a_flag_applies: assert property ((!brake_release_req) [*3] |-> !brake_release_flag_ff)
    else $error("release flag high without request");
  a_hold_cleared: assert property ($fell(controller_enabled_ff) |-> ##[0:2] !ramp_hold_ff)
    else $error("ramp hold kept after controller off");
  a_io2_quiet: assert property (!io2_oe_ff |-> !io2_out_ff)
    else $error("io2 drive value high while input");
  a_reset_pulse: assert property (drive_reset_ff |=> !drive_reset_ff)
    else $error("drive reset pulse too long");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_unmapped: assert property (arvalid && arready && araddr > 8'h13
    |=> rvalid && rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read answer");
endmodule // brake_output_setup_chk
bind brake_output_setup brake_output_setup_chk #(.ADDR_W(ADDR_W)) chk (.aclk(aclk),
  .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .brake_release_req(brake_release_req), .io2_out_ff(io2_out_ff), .io2_oe_ff(io2_oe_ff),
  .brake_release_flag_ff(brake_release_flag_ff), .controller_enabled_ff(controller_enabled_ff),
  .drive_reset_ff(drive_reset_ff), .ramp_hold_ff(ramp_hold_ff));
`default_nettype wire

/* tb/brake_model.sv */
// Electro-mechanical brake wired to the relay or to the io2 terminal.
`timescale 1ns/1ps
`default_nettype none
module brake_model (
  input wire logic aclk,
  input wire logic relay_coil,
  input wire logic io2_coil,
  input wire logic [1:0] wiring,
  output logic released
);
  always @(posedge aclk) begin
    released <= (wiring == 2'h1) ? relay_coil : (wiring == 2'h2) ? io2_coil : 1'b0;
  end
endmodule // brake_model
`default_nettype wire

/* tb/test_brake_output_setup.sv */
// Self-checking bench of the brake output set-up block.
`timescale 1ns/1ps
`default_nettype none
`include "brake_output_defs.vh"
module test_brake_output_setup;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic req = 0, dok = 0, io2_ext = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [3:0] wstrb = 0;
  logic [1:0] wiring = 0, sel_old, sel_new, mode;
  logic [6:0] rt;
  logic [4:0] mo;
  logic [31:0] seq = {2'h0, 2'h3, 2'h3, 2'h2, 2'h2, 2'h3, 2'h1, 2'h2, 2'h1, 2'h1, 2'h3, 2'h0, 2'h2,
    2'h0, 2'h1, 2'h0};
  wire awready, wready, bvalid, arready, rvalid, io2_out, io2_oe, relay, flag, en, drst, rel;
  wire rh, zh, pr, pm;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire io2_in = io2_oe ? io2_out : io2_ext;
  integer err_count = 0, tests_run = 0, i, seed = 32'hDB265260;
  brake_output_setup DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .brake_release_req(req), .drive_ok(dok), .io2_in(io2_in), .io2_out_ff(io2_out),
    .io2_oe_ff(io2_oe), .relay_out_ff(relay), .brake_release_flag_ff(flag),
    .controller_enabled_ff(en), .drive_reset_ff(drst), .ramp_hold_ff(rh),
    .zero_speed_hold_ff(zh), .posctl_ref_select_ff(pr), .posctl_mode_ff(pm));
  brake_model brake (.aclk(aclk), .relay_coil(relay), .io2_coil(io2_in), .wiring(wiring),
    .released(rel));
  initial forever #12.5 aclk = ~aclk;
  task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] v, input [3:0] s, input [1:0] er);
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= $random(seed);
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1 || !bready) begin
      if (bvalid === 1'b1) bready <= 1;
      @(posedge aclk);
    end
    check(bresp, er, "bresp");
    bready <= 0;
  endtask
  task rd(input [7:0] a, output [31:0] q, input [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= $random(seed);
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1 || !rready) begin
      if (rvalid === 1'b1) rready <= 1;
      @(posedge aclk);
    end
    q = rdata;
    check(rresp, er, "rresp");
    rready <= 0;
  endtask
  function [6:0] restore(input [1:0] o, input [6:0] r);
    restore = (o == 2'h1) ? 7'h42 : (o == 2'h2) ? {r[6:4], 4'h2} : r;
  endfunction
  function [6:0] setup(input [1:0] n, input [6:0] r);
    setup = (n == 2'h1) ? 7'h6C : (n == 2'h2) ? {r[6:4], 4'hE} : r;
  endfunction
  function srcv(input [1:0] c, input f);
    srcv = (c == 2'h3) ? f : (c == 2'h2) ? dok : 1'b0;
  endfunction
  initial begin
    #(25 * 20000);
    err_count++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(`BRK_OFS_ROUTING, d, `BRK_RESP_OKAY);
    check(d[6:0], 7'h42, "routing");
    rd(`BRK_OFS_STATUS, d, `BRK_RESP_OKAY);
    check(d[4:0], 5'h0, "status");
    rd(8'h14, d, `BRK_RESP_SLVERR);
    check(d, 32'h0, "rdata");
    wr(8'h14, 32'h3, 4'hF, `BRK_RESP_SLVERR);
    wr(`BRK_OFS_STATUS, 32'h7F, 4'hF, `BRK_RESP_OKAY);
    wr(`BRK_OFS_CTRL, 32'h3, 4'h2, `BRK_RESP_OKAY);
    rd(`BRK_OFS_CTRL, d, `BRK_RESP_OKAY);
    check(d[1:0], 2'h0, "ctrl");
    sel_old = 2'h0;
    for (i = 0; i < 28; i++) begin
      sel_new = (i < 16) ? seq[2*i+:2] : $random(seed);
      mode = $random(seed);
      mo = $random(seed);
      d = $random(seed);
      rt = i[0] ? {d[6:4], 4'h2} : d[6:0];
      req <= d[7];
      dok <= d[8];
      wr(`BRK_OFS_ROUTING, rt, 4'hF, `BRK_RESP_OKAY);
      wr(`BRK_OFS_MOTION, mo, 4'hF, `BRK_RESP_OKAY);
      wr(`BRK_OFS_DRIVE, mode, 4'hF, `BRK_RESP_OKAY);
      wr(`BRK_OFS_CTRL, sel_new, 4'h1, `BRK_RESP_OKAY);
      rd(`BRK_OFS_STATUS, d, `BRK_RESP_OKAY);
      check(d[2:1], sel_old, "applied");
      if (i[0]) begin
        io2_ext <= 1;
        repeat (4) @(posedge aclk);
        io2_ext <= 0;
      end else wr(`BRK_OFS_DRIVE, 32'h100 | mode, 4'h3, `BRK_RESP_OKAY);
      if (sel_new != sel_old) rt = setup(sel_new, restore(sel_old, rt));
      if (sel_old != 2'h0 && sel_new == 2'h0) begin
        mo[0] = 0;
        if (mode != 2'h0) begin
          mo[1] = 0;
          if (mo[4]) mo[3:2] = 2'h0;
        end
      end
      wiring <= sel_new;
      repeat (12) @(posedge aclk);
      rd(`BRK_OFS_ROUTING, d, `BRK_RESP_OKAY);
      check(d[6:0], rt, "routing");
      rd(`BRK_OFS_MOTION, d, `BRK_RESP_OKAY);
      check(d[4:0], mo, "motion");
      check({pm, pr, zh, rh}, mo[3:0], "holds");
      check(en, sel_new != 2'h0, "enabled");
      check(flag, (sel_new != 2'h0) & req, "flag");
      rd(`BRK_OFS_STATUS, d, `BRK_RESP_OKAY);
      check(d[4:1], {2'b01 & {1'b0, sel_new != 2'h0}, sel_new}, "status");
      check(io2_oe, rt[3], "io2_oe");
      if (rt[2:1] != 2'h1) check(io2_out, rt[3] & (srcv(rt[2:1], flag) ^ rt[0]), "io2");
      if (rt[6:5] != 2'h1) check(relay, srcv(rt[6:5], flag) ^ rt[4], "relay");
      check(rel, (sel_new == 2'h1) ? srcv(rt[6:5], flag) ^ rt[4] : (sel_new == 2'h2) ?
        rt[3] & (srcv(rt[2:1], flag) ^ rt[0]) : 1'b0, "brake");
      sel_old = sel_new;
    end
    conclude;
  end
endmodule // test_brake_output_setup
`default_nettype wire
